//--- ioex_pkg.sv
package ioex_pkg;

   // Widths of the core datapath, the bit-addressable port, the instruction code and the interrupt status
   localparam int ACC_W   = 4;
   localparam int DPORT_W = 10;
   localparam int OPC_W   = 10;
   localparam int IRQ_W   = 3;

   // Instruction codes handled by this block
   localparam logic [OPC_W-1:0] OPC_PORT4_WR  = 10'h224;
   localparam logic [OPC_W-1:0] OPC_D_SETALL  = 10'h011;
   localparam logic [OPC_W-1:0] OPC_D_CLR     = 10'h014;
   localparam logic [OPC_W-1:0] OPC_D_SET     = 10'h015;
   localparam logic [OPC_W-1:0] OPC_D_TEST    = 10'h024;
   localparam logic [OPC_W-1:0] OPC_C_CLR     = 10'h28C;
   localparam logic [OPC_W-1:0] OPC_C_SET     = 10'h28D;
   localparam logic [OPC_W-1:0] OPC_PU0_RD    = 10'h257;
   localparam logic [OPC_W-1:0] OPC_PU0_WR    = 10'h22D;
   localparam logic [OPC_W-1:0] OPC_PU1_RD    = 10'h25E;
   localparam logic [OPC_W-1:0] OPC_PU1_WR    = 10'h22E;
   localparam logic [OPC_W-1:0] OPC_SER_START = 10'h29E;
   localparam logic [OPC_W-1:0] OPC_SER_SKIP  = 10'h288;
   localparam logic [OPC_W-1:0] OPC_CERAMIC   = 10'h29A;
   localparam logic [OPC_W-1:0] OPC_RC        = 10'h29B;

   // Index limits of the bit-addressable port
   localparam logic [3:0] DTEST_Y_MAX = 4'h7;
   localparam logic [3:0] DPORT_Y_MAX = 4'h9;

   // Main clock source codes
   localparam logic [1:0] CLK_ONCHIP  = 2'h0;
   localparam logic [1:0] CLK_CERAMIC = 2'h1;
   localparam logic [1:0] CLK_RC      = 2'h2;

   // APB register byte offsets
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_STATE    = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
   localparam logic [7:0] ADDR_PORTS    = 8'h10;

   // Field positions
   localparam int CTRL_SIE_BIT     = 0;
   localparam int STATE_SDF_BIT    = 0;
   localparam int STATE_PORTC_BIT  = 1;
   localparam int STATE_CLKSEL_LSB = 2;
   localparam int STATE_OSCSTP_BIT = 4;
   localparam int STATE_PU0_LSB    = 8;
   localparam int STATE_PU1_LSB    = 12;
   localparam int PORTS_D_LSB      = 0;
   localparam int PORTS_P4_LSB     = 16;
   localparam int IRQ_SDONE_BIT    = 0;
   localparam int IRQ_SKIP_BIT     = 1;
   localparam int IRQ_BADTEST_BIT  = 2;

   // Reset values
   localparam logic [ACC_W-1:0]   RST_PORT4  = 4'h0;
   localparam logic [DPORT_W-1:0] RST_PORTD  = 10'h000;
   localparam logic               RST_PORTC  = 1'b0;
   localparam logic [ACC_W-1:0]   RST_PU     = 4'h0;
   localparam logic [1:0]         RST_CLKSEL = 2'h0;
   localparam logic [IRQ_W-1:0]   RST_MASK   = 3'h0;
   localparam logic               RST_SIE    = 1'b0;

   // Decoded operation, one-hot
   typedef enum logic [15:0] {
      OP_NONE      = 16'h0001,
      OP_PORT4_WR  = 16'h0002,
      OP_D_SETALL  = 16'h0004,
      OP_D_CLR     = 16'h0008,
      OP_D_SET     = 16'h0010,
      OP_D_TEST    = 16'h0020,
      OP_C_CLR     = 16'h0040,
      OP_C_SET     = 16'h0080,
      OP_PU0_RD    = 16'h0100,
      OP_PU0_WR    = 16'h0200,
      OP_PU1_RD    = 16'h0400,
      OP_PU1_WR    = 16'h0800,
      OP_SER_START = 16'h1000,
      OP_SER_SKIP  = 16'h2000,
      OP_CERAMIC   = 16'h4000,
      OP_RC        = 16'h8000
   } ioex_op_t;

endpackage : ioex_pkg

//--- ioex_dec_if.sv
`timescale 1ns/1ns
interface ioex_dec_if;
   import ioex_pkg::*;

   ioex_op_t op;

   modport src (output op);
   modport snk (input op);
endinterface : ioex_dec_if

//--- ioex_decode.sv
`timescale 1ns/1ns
module ioex_decode
   import ioex_pkg::*;
(
   input  wire logic                          instr_valid_i,
   input  wire logic [ioex_pkg::OPC_W-1:0]    instr_code_i,
   ioex_dec_if.src                            dec
);

   // Maps one fetched word onto a one-hot operation
   always_comb
   begin
      dec.op = OP_NONE;
      if (instr_valid_i)
      begin
         case (instr_code_i)
            OPC_PORT4_WR:  dec.op = OP_PORT4_WR;
            OPC_D_SETALL:  dec.op = OP_D_SETALL;
            OPC_D_CLR:     dec.op = OP_D_CLR;
            OPC_D_SET:     dec.op = OP_D_SET;
            OPC_D_TEST:    dec.op = OP_D_TEST;
            OPC_C_CLR:     dec.op = OP_C_CLR;
            OPC_C_SET:     dec.op = OP_C_SET;
            OPC_PU0_RD:    dec.op = OP_PU0_RD;
            OPC_PU0_WR:    dec.op = OP_PU0_WR;
            OPC_PU1_RD:    dec.op = OP_PU1_RD;
            OPC_PU1_WR:    dec.op = OP_PU1_WR;
            OPC_SER_START: dec.op = OP_SER_START;
            OPC_SER_SKIP:  dec.op = OP_SER_SKIP;
            OPC_CERAMIC:   dec.op = OP_CERAMIC;
            OPC_RC:        dec.op = OP_RC;
            default:       dec.op = OP_NONE;
         endcase
      end
   end

endmodule : ioex_decode

//--- ioex_top.sv
// Behaviour
// [RULE_01] Port-four write copies the accumulator onto the port-four latch.
// [RULE_02] Set-all loads one into every bit of the bit-addressable port.
// [RULE_03] Bit-clear writes zero only to the bit selected by the index.
// [RULE_04] Bit-set writes one only to the bit selected by the index.
// [RULE_05] Bit-test skips the next instruction when the indexed bit is zero.
// [RULE_06] Program uses bit-test only with index values 0 to 7.
// [RULE_07] Single-bit port clear drives that port to zero.
// [RULE_08] Single-bit port set drives that port to one.
// [RULE_09] First pull-up read copies that register into the accumulator.
// [RULE_10] First pull-up write loads the accumulator into that register.
// [RULE_11] Second pull-up read copies that register into the accumulator.
// [RULE_12] Second pull-up write loads the accumulator into that register.
// [RULE_13] Serial-done skip clears the flag after skipping; no-op if enable is one.
// [RULE_14] Serial start clears the serial-done flag and starts a transfer.
// [RULE_15] With enable zero, serial-done skip skips when the flag is one.
// [RULE_16] Ceramic select switches main clock to ceramic, stops on-chip oscillator.
// [RULE_17] RC select switches main clock to RC, stops on-chip oscillator.
// [RULE_18] Each instruction takes one word and one cycle, visible next cycle.
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ns
module ioex_top
(
   input  wire logic                            mclk_i,
   input  wire logic                            reset_i,
   input  wire logic                            clk_en_i,
   input  wire logic                            psel_i,
   input  wire logic                            penable_i,
   input  wire logic                            pwrite_i,
   input  wire logic [7:0]                      paddr_i,
   input  wire logic [31:0]                     pwdata_i,
   output logic      [31:0]                     prdata_o,
   output logic                                 pready_o,
   output logic                                 pslverr_o,
   input  wire logic                            instr_valid_i,
   input  wire logic [ioex_pkg::OPC_W-1:0]      instr_code_i,
   input  wire logic [ioex_pkg::ACC_W-1:0]      acc_i,
   input  wire logic [3:0]                      y_index_i,
   input  wire logic                            serial_xfer_done_i,
   output logic      [ioex_pkg::ACC_W-1:0]      output_port_four_o,
   output logic      [ioex_pkg::DPORT_W-1:0]    port_d_o,
   output logic                                 port_c_o,
   output logic      [ioex_pkg::ACC_W-1:0]      pullup_control_first_o,
   output logic      [ioex_pkg::ACC_W-1:0]      pullup_control_second_o,
   output logic                                 acc_load_o,
   output logic      [ioex_pkg::ACC_W-1:0]      acc_data_o,
   output logic                                 skip_next_o,
   output logic                                 serial_start_op_o,
   output logic                                 serial_done_flag_o,
   output logic      [1:0]                      main_clk_sel_o,
   output logic                                 onchip_osc_stop_o,
   output logic                                 irq_o
);
   import ioex_pkg::*;

   // One-hot mask of the port bit named by the index; empty beyond the port
   function automatic logic [DPORT_W-1:0] y_mask(input logic [3:0] y);
      logic [DPORT_W-1:0] m;
      m = '0;
      if (y <= DPORT_Y_MAX)
      begin
         m[y] = 1'b1;
      end
      return m;
   endfunction : y_mask

   ioex_dec_if dec ();

   // Instruction word decode
   ioex_decode u_decode
   (
      .instr_valid_i (instr_valid_i),
      .instr_code_i  (instr_code_i),
      .dec           (dec)
   );

   logic                 serial_irq_enable_bit;
   logic [IRQ_W-1:0]     irq_stat;
   logic [IRQ_W-1:0]     irq_mask;
   logic                 next_sie;
   logic [IRQ_W-1:0]     next_irq_stat;
   logic [IRQ_W-1:0]     next_irq_mask;
   logic                 next_irq;
   logic [ACC_W-1:0]     next_port4;
   logic [DPORT_W-1:0]   next_port_d;
   logic                 next_port_c;
   logic [ACC_W-1:0]     next_pu0;
   logic [ACC_W-1:0]     next_pu1;
   logic                 next_sdf;
   logic [1:0]           next_clk_sel;
   logic                 next_osc_stop;
   logic                 next_acc_load;
   logic [ACC_W-1:0]     next_acc_data;
   logic                 next_skip;
   logic                 next_ser_start;
   logic                 next_bad_test;
   logic [31:0]          next_prdata;
   logic                 next_pready;
   logic                 next_pslverr;
   logic                 apb_wr;
   logic                 d_bit;

   // Bit of the port picked by the index; out of range reads as one
   assign d_bit = |(port_d_o & y_mask(y_index_i)) | (y_index_i > DPORT_Y_MAX);

   // Port, pull-up, flag and clock-source state for the current instruction
   always_comb
   begin
      next_port4    = output_port_four_o;
      next_port_d   = port_d_o;
      next_port_c   = port_c_o;
      next_pu0      = pullup_control_first_o;
      next_pu1      = pullup_control_second_o;
      next_sdf      = serial_done_flag_o;
      next_clk_sel  = main_clk_sel_o;
      next_osc_stop = onchip_osc_stop_o;
      case (dec.op)
         OP_PORT4_WR:  next_port4  = acc_i;                          // see [RULE_01]
         OP_D_SETALL:  next_port_d = '1;                             // see [RULE_02]
         OP_D_CLR:     next_port_d = port_d_o & ~y_mask(y_index_i);  // see [RULE_03]
         OP_D_SET:     next_port_d = port_d_o | y_mask(y_index_i);   // see [RULE_04]
         OP_C_CLR:     next_port_c = 1'b0;                           // see [RULE_07]
         OP_C_SET:     next_port_c = 1'b1;                           // see [RULE_08]
         OP_PU0_WR:    next_pu0    = acc_i;                          // see [RULE_10]
         OP_PU1_WR:    next_pu1    = acc_i;                          // see [RULE_12]
         OP_SER_START: next_sdf    = 1'b0;                           // see [RULE_14]
         OP_SER_SKIP:
         begin
            if (!serial_irq_enable_bit)
            begin
               next_sdf = 1'b0;                                      // see [RULE_13]
            end
         end
         OP_CERAMIC:
         begin
            next_clk_sel  = CLK_CERAMIC;                             // see [RULE_16]
            next_osc_stop = 1'b1;
         end
         OP_RC:
         begin
            next_clk_sel  = CLK_RC;                                  // see [RULE_17]
            next_osc_stop = 1'b1;
         end
         default:      next_port4  = output_port_four_o;
      endcase
      // A completed transfer in the same cycle beats any clear
      if (serial_xfer_done_i)
      begin
         next_sdf = 1'b1;
      end
   end

   // Registers the instruction results; one cycle per instruction
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         output_port_four_o      <= RST_PORT4;
         port_d_o                <= RST_PORTD;
         port_c_o                <= RST_PORTC;
         pullup_control_first_o  <= RST_PU;
         pullup_control_second_o <= RST_PU;
         serial_done_flag_o      <= 1'b0;
         main_clk_sel_o          <= RST_CLKSEL;
         onchip_osc_stop_o       <= 1'b0;
      end
      else if (clk_en_i)
      begin
         output_port_four_o      <= next_port4;                     // see [RULE_18]
         port_d_o                <= next_port_d;
         port_c_o                <= next_port_c;
         pullup_control_first_o  <= next_pu0;
         pullup_control_second_o <= next_pu1;
         serial_done_flag_o      <= next_sdf;
         main_clk_sel_o          <= next_clk_sel;
         onchip_osc_stop_o       <= next_osc_stop;
      end
   end

   // One-cycle answers to the core: accumulator load, skip, serial start
   always_comb
   begin
      next_acc_load  = 1'b0;
      next_acc_data  = acc_data_o;
      next_skip      = 1'b0;
      next_ser_start = 1'b0;
      next_bad_test  = 1'b0;
      case (dec.op)
         OP_PU0_RD:
         begin
            next_acc_load = 1'b1;
            next_acc_data = pullup_control_first_o;                  // see [RULE_09]
         end
         OP_PU1_RD:
         begin
            next_acc_load = 1'b1;
            next_acc_data = pullup_control_second_o;                 // see [RULE_11]
         end
         OP_D_TEST:
         begin
            next_skip     = ~d_bit;                                  // see [RULE_05]
            next_bad_test = (y_index_i > DTEST_Y_MAX);               // see [RULE_06]
         end
         OP_SER_SKIP:  next_skip = ~serial_irq_enable_bit & serial_done_flag_o; // see [RULE_15]
         OP_SER_START: next_ser_start = 1'b1;                        // see [RULE_14]
         default:      next_skip = 1'b0;
      endcase
   end

   // Registers the core answers
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         acc_load_o        <= 1'b0;
         acc_data_o        <= '0;
         skip_next_o       <= 1'b0;
         serial_start_op_o <= 1'b0;
      end
      else if (clk_en_i)
      begin
         acc_load_o        <= next_acc_load;
         acc_data_o        <= next_acc_data;
         skip_next_o       <= next_skip;
         serial_start_op_o <= next_ser_start;
      end
   end

   // APB: answer prepared in the setup cycle, given in the first access cycle
   assign apb_wr = psel_i & penable_i & pready_o & pwrite_i;

   always_comb
   begin
      next_pready  = psel_i & ~penable_i;
      next_pslverr = 1'b0;
      next_prdata  = '0;
      case (paddr_i)
         ADDR_CTRL:     next_prdata[CTRL_SIE_BIT] = serial_irq_enable_bit;
         ADDR_STATE:
         begin
            next_prdata[STATE_SDF_BIT]                = serial_done_flag_o;
            next_prdata[STATE_PORTC_BIT]              = port_c_o;
            next_prdata[STATE_CLKSEL_LSB +: 2]        = main_clk_sel_o;
            next_prdata[STATE_OSCSTP_BIT]             = onchip_osc_stop_o;
            next_prdata[STATE_PU0_LSB +: ACC_W]       = pullup_control_first_o;
            next_prdata[STATE_PU1_LSB +: ACC_W]       = pullup_control_second_o;
         end
         ADDR_IRQ_STAT: next_prdata[IRQ_W-1:0] = irq_stat;
         ADDR_IRQ_MASK: next_prdata[IRQ_W-1:0] = irq_mask;
         ADDR_PORTS:
         begin
            next_prdata[PORTS_D_LSB +: DPORT_W] = port_d_o;
            next_prdata[PORTS_P4_LSB +: ACC_W]  = output_port_four_o;
         end
         default:       next_pslverr = psel_i & ~penable_i;
      endcase
      if (!(psel_i & ~penable_i))
      begin
         next_prdata = prdata_o;
      end
   end

   // Registers the APB answer
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         prdata_o  <= '0;
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end
      else if (clk_en_i)
      begin
         prdata_o  <= next_prdata;
         pready_o  <= next_pready;
         pslverr_o <= next_pslverr;
      end
   end

   // Control, sticky event status (write one to clear) and mask
   always_comb
   begin
      next_sie      = serial_irq_enable_bit;
      next_irq_mask = irq_mask;
      next_irq_stat = irq_stat;
      if (apb_wr && paddr_i == ADDR_CTRL)
      begin
         next_sie = pwdata_i[CTRL_SIE_BIT];
      end
      if (apb_wr && paddr_i == ADDR_IRQ_MASK)
      begin
         next_irq_mask = pwdata_i[IRQ_W-1:0];
      end
      if (apb_wr && paddr_i == ADDR_IRQ_STAT)
      begin
         next_irq_stat = irq_stat & ~pwdata_i[IRQ_W-1:0];
      end
      // Events set after the clear so a same-cycle event is kept
      next_irq_stat[IRQ_SDONE_BIT]   = next_irq_stat[IRQ_SDONE_BIT] | serial_xfer_done_i;
      next_irq_stat[IRQ_SKIP_BIT]    = next_irq_stat[IRQ_SKIP_BIT] | next_skip;
      next_irq_stat[IRQ_BADTEST_BIT] = next_irq_stat[IRQ_BADTEST_BIT] | next_bad_test;
      next_irq = |(next_irq_stat & next_irq_mask);
   end

   // Registers control and interrupt state
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         serial_irq_enable_bit <= RST_SIE;
         irq_mask              <= RST_MASK;
         irq_stat              <= '0;
         irq_o                 <= 1'b0;
      end
      else if (clk_en_i)
      begin
         serial_irq_enable_bit <= next_sie;
         irq_mask              <= next_irq_mask;
         irq_stat              <= next_irq_stat;
         irq_o                 <= next_irq;
      end
   end

endmodule : ioex_top

//--- ioex_checker_properties.sv
`timescale 1ns/1ns
module ioex_checker
(
   input wire logic       mclk_i,
   input wire logic       reset_i,
   input wire logic       clk_en_i,
   input wire logic       instr_valid_i,
   input wire logic [9:0] instr_code_i,
   input wire logic [3:0] acc_i,
   input wire logic [3:0] y_index_i,
   input wire logic       serial_xfer_done_i,
   input wire logic [3:0] output_port_four_o,
   input wire logic [9:0] port_d_o,
   input wire logic       port_c_o,
   input wire logic [3:0] pullup_control_first_o,
   input wire logic [3:0] pullup_control_second_o,
   input wire logic       acc_load_o,
   input wire logic [3:0] acc_data_o,
   input wire logic       skip_next_o,
   input wire logic       serial_start_op_o,
   input wire logic       serial_done_flag_o,
   input wire logic [1:0] main_clk_sel_o,
   input wire logic       onchip_osc_stop_o
);
   import ioex_pkg::*;
   // Instruction taken at this edge
   wire logic       go = instr_valid_i && clk_en_i;
   wire logic [9:0] c  = instr_code_i;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);

   a_port4_load: assert property (go && c == OPC_PORT4_WR
      |=> output_port_four_o == $past(acc_i)) else $error("port four not loaded");
   a_setall_ones: assert property (go && c == OPC_D_SETALL
      |=> port_d_o == 10'h3FF) else $error("port d not all ones");
   a_bit_clear: assert property (go && c == OPC_D_CLR && y_index_i <= DPORT_Y_MAX
      |=> port_d_o == ($past(port_d_o) & ~(10'h001 << $past(y_index_i))))
      else $error("port d bit clear wrong");
   a_bit_set: assert property (go && c == OPC_D_SET && y_index_i <= DPORT_Y_MAX
      |=> port_d_o == ($past(port_d_o) | (10'h001 << $past(y_index_i))))
      else $error("port d bit set wrong");
   a_test_skip: assert property (go && c == OPC_D_TEST && y_index_i <= DTEST_Y_MAX
      |=> skip_next_o == !$past(port_d_o[y_index_i])) else $error("bit test skip wrong");
   a_portc_clear: assert property (go && c == OPC_C_CLR |=> !port_c_o)
      else $error("port c not cleared");
   a_portc_set: assert property (go && c == OPC_C_SET |=> port_c_o)
      else $error("port c not set");
   a_first_read: assert property (go && c == OPC_PU0_RD |=> acc_load_o
      && acc_data_o == $past(pullup_control_first_o) && $stable(pullup_control_first_o))
      else $error("first pull-up read wrong");
   a_first_write: assert property (go && c == OPC_PU0_WR
      |=> pullup_control_first_o == $past(acc_i)) else $error("first pull-up write wrong");
   a_second_read: assert property (go && c == OPC_PU1_RD |=> acc_load_o
      && acc_data_o == $past(pullup_control_second_o) && $stable(pullup_control_second_o))
      else $error("second pull-up read wrong");
   a_second_write: assert property (go && c == OPC_PU1_WR
      |=> pullup_control_second_o == $past(acc_i)) else $error("second pull-up write wrong");
   a_skip_clears: assert property (go && c == OPC_SER_SKIP && !serial_xfer_done_i
      ##1 skip_next_o |-> !serial_done_flag_o) else $error("flag kept after skip");
   a_skip_idle: assert property (go && c == OPC_SER_SKIP && !serial_done_flag_o
      |=> !skip_next_o) else $error("skip without flag");
   a_start_clears: assert property (go && c == OPC_SER_START && !serial_xfer_done_i
      |=> serial_start_op_o && !serial_done_flag_o) else $error("serial start wrong");
   a_ceramic_sel: assert property (go && c == OPC_CERAMIC
      |=> main_clk_sel_o == CLK_CERAMIC && onchip_osc_stop_o) else $error("ceramic select wrong");
   a_rc_sel: assert property (go && c == OPC_RC
      |=> main_clk_sel_o == CLK_RC && onchip_osc_stop_o) else $error("rc select wrong");
endmodule : ioex_checker

bind ioex_top ioex_checker u_chk (.mclk_i, .reset_i, .clk_en_i, .instr_valid_i, .instr_code_i,
   .acc_i, .y_index_i, .serial_xfer_done_i, .output_port_four_o, .port_d_o, .port_c_o,
   .pullup_control_first_o, .pullup_control_second_o, .acc_load_o, .acc_data_o,
   .skip_next_o, .serial_start_op_o, .serial_done_flag_o, .main_clk_sel_o, .onchip_osc_stop_o);

//--- ioex_core_model.sv
`timescale 1ns/1ns
module ioex_core_model
(
   input  wire logic       mclk_i,
   input  wire logic       reset_i,
   input  wire logic       acc_load_i,
   input  wire logic [3:0] acc_data_i,
   input  wire logic       skip_next_i,
   output logic      [3:0] acc_o,
   output logic      [7:0] skips_o
);
   // Accumulator takes read results; skipped words are counted
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         acc_o   <= 4'h0;
         skips_o <= 8'h00;
      end
      else
      begin
         if (acc_load_i)
            acc_o <= acc_data_i;
         if (skip_next_i)
            skips_o <= skips_o + 8'h01;
      end
   end
endmodule : ioex_core_model

//--- tb_top.sv
`timescale 1ns/1ns
module tb_top;
   import ioex_pkg::*;
   logic        mclk_i, reset_i, psel_i, penable_i, pwrite_i, instr_valid_i;
   logic        serial_xfer_done_i, pready_o, pslverr_o, port_c_o, acc_load_o, skip_next_o;
   logic        serial_start_op_o, serial_done_flag_o, onchip_osc_stop_o, irq_o;
   logic [7:0]  paddr_i;
   logic [31:0] pwdata_i, prdata_o;
   logic [9:0]  instr_code_i, port_d_o, m_d;
   logic [3:0]  acc_i, y_index_i, output_port_four_o, acc_data_o, core_acc;
   logic [3:0]  pullup_control_first_o, pullup_control_second_o, m_p4, m_pu0, m_pu1, m_ad;
   logic [2:0]  m_is, m_mask;
   logic [1:0]  main_clk_sel_o, m_cs;
   logic        m_c, m_fl, m_os, m_sie;
   logic [33:0] notes[$];
   int          errors = 0, compares = 0;

   ioex_top u_dut (.mclk_i, .reset_i, .clk_en_i(1'b1), .psel_i, .penable_i, .pwrite_i,
      .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .instr_valid_i, .instr_code_i,
      .acc_i, .y_index_i, .serial_xfer_done_i, .output_port_four_o, .port_d_o, .port_c_o,
      .pullup_control_first_o, .pullup_control_second_o, .acc_load_o, .acc_data_o,
      .skip_next_o, .serial_start_op_o, .serial_done_flag_o, .main_clk_sel_o,
      .onchip_osc_stop_o, .irq_o);
   ioex_core_model u_core (.mclk_i, .reset_i, .acc_load_i(acc_load_o), .acc_data_i(acc_data_o),
      .skip_next_i(skip_next_o), .acc_o(core_acc), .skips_o());

   // Free-running core clock
   always #50 mclk_i = ~mclk_i;

   task automatic summarize();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : summarize

   task automatic take(input logic [33:0] seen);
      compares++;
      if (notes.size() == 0 || seen !== notes[0])
      begin
         errors++;
         $display("BAD %0t seen %h", $time, seen);
      end
      if (notes.size() != 0)
         void'(notes.pop_front());
   endtask : take

   // Oldest note against each read answer and each executed instruction
   always @(posedge mclk_i)
   begin
      if (psel_i && penable_i && pready_o && !pwrite_i)
         take({irq_o, pslverr_o, prdata_o});
      if (instr_valid_i)
      begin
         #1;
         take({output_port_four_o, port_d_o, port_c_o, pullup_control_first_o,
            pullup_control_second_o, acc_load_o, acc_data_o, skip_next_o, serial_start_op_o,
            serial_done_flag_o, main_clk_sel_o, onchip_osc_stop_o});
      end
   end

   // One instruction word, reference state advanced alongside
   task automatic op(input logic [9:0] code, input logic [3:0] a, input logic [3:0] y);
      logic ld, sk, ss;
      {psel_i, penable_i} <= 2'h0;
      {instr_valid_i, instr_code_i, acc_i, y_index_i} <= {1'b1, code, a, y};
      @(posedge mclk_i);
      {ld, sk, ss} = 3'h0;
      case (code)
         OPC_PORT4_WR: m_p4 = a;
         OPC_D_SETALL: m_d = 10'h3FF;
         OPC_D_CLR: if (y <= DPORT_Y_MAX) m_d[y] = 1'b0;
         OPC_D_SET: if (y <= DPORT_Y_MAX) m_d[y] = 1'b1;
         OPC_D_TEST: sk = (y <= DPORT_Y_MAX) && !m_d[y];
         OPC_C_CLR: m_c = 1'b0;
         OPC_C_SET: m_c = 1'b1;
         OPC_PU0_RD: {ld, m_ad} = {1'b1, m_pu0};
         OPC_PU0_WR: m_pu0 = a;
         OPC_PU1_RD: {ld, m_ad} = {1'b1, m_pu1};
         OPC_PU1_WR: m_pu1 = a;
         OPC_SER_START: {ss, m_fl} = 2'h2;
         OPC_SER_SKIP: if (!m_sie && m_fl) {sk, m_fl} = 2'h2;
         OPC_CERAMIC: {m_cs, m_os} = {CLK_CERAMIC, 1'b1};
         OPC_RC: {m_cs, m_os} = {CLK_RC, 1'b1};
         default: ;
      endcase
      m_is[IRQ_SKIP_BIT] = m_is[IRQ_SKIP_BIT] | sk;
      notes.push_back({m_p4, m_d, m_c, m_pu0, m_pu1, ld, m_ad, sk, ss, m_fl, m_cs, m_os});
   endtask : op

   // Serial unit reports a finished transfer
   task automatic sdone();
      {instr_valid_i, serial_xfer_done_i} <= 2'h1;
      @(posedge mclk_i);
      serial_xfer_done_i <= 1'b0;
      {m_fl, m_is[IRQ_SDONE_BIT]} = 2'h3;
   endtask : sdone

   // One APB transfer; e is the expected {pslverr, prdata} of a read
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      int n;
      instr_valid_i <= 1'b0;
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'h2, w, a, d};
      @(posedge mclk_i);
      penable_i <= 1'b1;
      if (!w)
         notes.push_back({|(m_is & m_mask), e});
      for (n = 0; n < 20 && pready_o !== 1'b1; n++)
         @(posedge mclk_i);
      if (pready_o !== 1'b1)
      begin
         errors++;
         summarize();
      end
      if (w && a == ADDR_CTRL)
         m_sie = d[CTRL_SIE_BIT];
      if (w && a == ADDR_IRQ_MASK)
         m_mask = d[2:0];
      if (w && a == ADDR_IRQ_STAT)
         m_is = m_is & ~d[2:0];
   endtask : apb

   // Main sequence
   initial
   begin
      {mclk_i, psel_i, penable_i, pwrite_i, instr_valid_i, serial_xfer_done_i} = 6'h00;
      {reset_i, paddr_i, pwdata_i, instr_code_i, acc_i, y_index_i} = {1'b1, 58'h0};
      {m_p4, m_pu0, m_pu1, m_ad, m_d, m_is, m_mask, m_cs, m_c, m_fl, m_os, m_sie} = '0;
      void'($urandom(32'hEA53));
      repeat (16) @(posedge mclk_i);
      reset_i <= 1'b0;
      apb(1'b0, ADDR_STATE, 32'h0, 33'h0);
      repeat (4) op(OPC_PORT4_WR, 4'($urandom), 4'($urandom));
      op(OPC_D_SETALL, 4'h0, 4'h0);
      for (int i = 0; i < 16; i++) op(OPC_D_CLR, 4'($urandom), 4'(i));
      for (int i = 1; i < 16; i += 2) op(OPC_D_SET, 4'($urandom), 4'(i));
      for (int i = 0; i < 8; i++) op(OPC_D_TEST, 4'($urandom), 4'(i));
      op(OPC_C_SET, 4'h0, 4'h0);
      op(OPC_C_CLR, 4'h0, 4'h0);
      op(OPC_C_SET, 4'h0, 4'h0);
      op(OPC_PU0_WR, 4'($urandom), 4'h0);
      op(OPC_PU1_WR, 4'($urandom), 4'h0);
      op(OPC_PU0_RD, 4'h0, 4'h0);
      repeat (2) op(10'h000, 4'($urandom), 4'h0);
      op(OPC_PU1_WR, core_acc, 4'h0);
      op(OPC_PU1_RD, 4'h0, 4'h0);
      sdone();
      op(OPC_SER_SKIP, 4'h0, 4'h0);
      op(OPC_SER_SKIP, 4'h0, 4'h0);
      apb(1'b1, ADDR_CTRL, 32'h1, 33'h0);
      sdone();
      op(OPC_SER_SKIP, 4'h0, 4'h0);
      op(OPC_SER_START, 4'h0, 4'h0);
      op(OPC_SER_START, 4'h0, 4'h0);
      op(OPC_CERAMIC, 4'h0, 4'h0);
      op(OPC_RC, 4'h0, 4'h0);
      op(OPC_CERAMIC, 4'h0, 4'h0);
      apb(1'b0, ADDR_IRQ_STAT, 32'h0, {30'h0, m_is});
      apb(1'b1, ADDR_IRQ_MASK, 32'h3, 33'h0);
      for (int i = 1; i < 4; i++)
      begin
         apb(1'b0, ADDR_IRQ_STAT, 32'h0, {30'h0, m_is});
         apb(1'b1, ADDR_IRQ_STAT, 32'(i), 33'h0);
      end
      apb(1'b0, ADDR_STATE, 32'h0, {17'h0, m_pu1, m_pu0, 3'h0, m_os, m_cs, m_c, m_fl});
      apb(1'b0, ADDR_PORTS, 32'h0, {13'h0, m_p4, 6'h0, m_d});
      apb(1'b0, ADDR_CTRL, 32'h0, {32'h0, m_sie});
      apb(1'b0, 8'hFC, 32'h0, {1'b1, 32'h0});
      op(10'h000, 4'h0, 4'h0);
      instr_valid_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      errors += notes.size();
      summarize();
   end
endmodule : tb_top
